// ===== logic/adcc_top.sv
`timescale 1ns/1ps
// Operation
// - control/status clears on reset and standby
// - end flag after single or full scan
// - end flag cleared by read-1 then write-0
// - bit 6 gates end interrupt request
// - start bit set, held, single auto-clear
// - scan repeats until start cleared
// - bit 4 selects single or scan
// - bit 3 selects 266 or 134 states
// - group bit plus channel field selection
// - trigger register resets to 0x7F
// - enabled falling trigger edge starts conversion
// - trigger bits 6..0 read one
// - upper read returns byte, latches lower
// - lower read returns holding latch
// - results left-justified, low six zero
// - result goes to register by position
module adcc_top
  import adcc_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic       standby,
  // 8-bit internal register bus
  input  wire logic [3:0] bus_addr,
  input  wire logic       bus_rd,
  input  wire logic       bus_wr,
  input  wire logic [7:0] bus_wdata,
  output logic      [7:0] bus_rdata,
  // converter interface
  input  wire logic       ext_trigger_n,
  output logic      [2:0] conv_channel,
  output logic            conv_sample,
  input  wire logic [9:0] conv_value,
  // interrupt request
  output logic            conv_end_irq
);
  logic        conv_end_flag_ff;
  logic        end_irq_enable_ff;
  logic        conv_start_bit_ff;
  logic        scan_mode_ff;
  logic        conv_speed_select_ff;
  logic        group_select_ff;
  logic [1:0]  chan_sel_ff;
  logic        ext_trigger_enable_ff;
  logic        end_seen_ff;
  logic        trig_d_ff;
  logic        rd_csr_ff;
  logic        rd_mem_ff;
  logic [7:0]  reg_rdata_ff;
  adcc_state_t state_ff;
  logic [8:0]  cnt_ff;
  logic [1:0]  pos_ff;
  logic [7:0]  mem_rdata;
  logic        csr_wr;
  logic        trig_fall;
  logic        conv_done;
  logic        last_pos;
  logic        set_end;
  logic        auto_clr;
  logic        start_req;

  assign csr_wr    = bus_wr && bus_addr == ADCC_OFS_CSR;
  // falling edge of the trigger pin, honoured only when enabled
  assign trig_fall = ext_trigger_enable_ff && trig_d_ff
                     && !ext_trigger_n;
  assign conv_done = state_ff == ADCC_CONV && cnt_ff == 9'h000;
  // scan pass ends at position n of the channel field, then wraps to 0
  assign last_pos  = !scan_mode_ff || pos_ff == chan_sel_ff;
  assign set_end   = conv_done && last_pos;
  assign auto_clr  = conv_done && !scan_mode_ff;
  assign start_req = trig_fall
                   || (csr_wr && bus_wdata[ADCC_BIT_START]);

  // trigger pin delay for edge detection
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      trig_d_ff <= 1'b1;
    else
      trig_d_ff <= ext_trigger_n;
  end

  // control fields of the control/status register
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      end_irq_enable_ff    <= ADCC_CSR_RST[ADCC_BIT_IEN];
      scan_mode_ff         <= ADCC_CSR_RST[ADCC_BIT_SCAN];
      conv_speed_select_ff <= ADCC_CSR_RST[ADCC_BIT_SPEED];
      group_select_ff      <= ADCC_CSR_RST[ADCC_BIT_GROUP];
      chan_sel_ff          <= ADCC_CSR_RST[1:0];
    end
    else if (standby)
    begin
      end_irq_enable_ff    <= ADCC_CSR_RST[ADCC_BIT_IEN];
      scan_mode_ff         <= ADCC_CSR_RST[ADCC_BIT_SCAN];
      conv_speed_select_ff <= ADCC_CSR_RST[ADCC_BIT_SPEED];
      group_select_ff      <= ADCC_CSR_RST[ADCC_BIT_GROUP];
      chan_sel_ff          <= ADCC_CSR_RST[1:0];
    end
    else if (csr_wr)
    begin
      end_irq_enable_ff    <= bus_wdata[ADCC_BIT_IEN];
      scan_mode_ff         <= bus_wdata[ADCC_BIT_SCAN];
      conv_speed_select_ff <= bus_wdata[ADCC_BIT_SPEED];
      group_select_ff      <= bus_wdata[ADCC_BIT_GROUP];
      chan_sel_ff          <= bus_wdata[1:0];
    end
  end

  // start bit: set by software or trigger, cleared by software or single-mode done
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      conv_start_bit_ff <= 1'b0;
    else if (standby)
      conv_start_bit_ff <= 1'b0;
    else if (start_req)
      conv_start_bit_ff <= 1'b1;
    else if (csr_wr)
      conv_start_bit_ff <= 1'b0;
    else if (auto_clr)
      conv_start_bit_ff <= 1'b0;
  end

  // end flag: set wins, clear needs a prior read of it as one
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      conv_end_flag_ff <= 1'b0;
      end_seen_ff      <= 1'b0;
    end
    else if (standby)
    begin
      conv_end_flag_ff <= 1'b0;
      end_seen_ff      <= 1'b0;
    end
    else if (set_end)
    begin
      conv_end_flag_ff <= 1'b1;
      end_seen_ff      <= 1'b0;
    end
    else if (csr_wr && !bus_wdata[ADCC_BIT_END] && end_seen_ff)
    begin
      conv_end_flag_ff <= 1'b0;
      end_seen_ff      <= 1'b0;
    end
    else if (rd_csr_ff && conv_end_flag_ff)
      end_seen_ff <= 1'b1;
  end

  // note a status read for the arming of the flag clear, and which
  // source answers the read in flight
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rd_csr_ff <= 1'b0;
      rd_mem_ff <= 1'b0;
    end
    else
    begin
      rd_csr_ff <= bus_rd && bus_addr == ADCC_OFS_CSR;
      rd_mem_ff <= bus_rd && bus_addr[3] == 1'b0;
    end
  end

  // trigger enable; other bits are fixed ones
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      ext_trigger_enable_ff <= ADCC_TRIG_RST[ADCC_BIT_TEN];
    else if (standby)
      ext_trigger_enable_ff <= ADCC_TRIG_RST[ADCC_BIT_TEN];
    else if (bus_wr && bus_addr == ADCC_OFS_TRIG)
      ext_trigger_enable_ff <= bus_wdata[ADCC_BIT_TEN];
  end

  // conversion sequencer: counts states, steps channel position
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_ff <= ADCC_IDLE;
      cnt_ff   <= 9'h000;
      pos_ff   <= 2'h0;
    end
    else if (standby || !conv_start_bit_ff || start_req)
    begin
      state_ff <= conv_start_bit_ff || start_req ? ADCC_CONV : ADCC_IDLE;
      cnt_ff   <= conv_speed_select_ff && !(csr_wr && !bus_wdata[3])
                  || csr_wr && bus_wdata[ADCC_BIT_SPEED]
                  ? ADCC_CONV_FAST : ADCC_CONV_SLOW;
      pos_ff   <= 2'h0;
      if (standby)
        state_ff <= ADCC_IDLE;
    end
    else
    begin
      case (state_ff)
        ADCC_IDLE:
          state_ff <= ADCC_CONV;
        ADCC_CONV:
          if (conv_done)
          begin
            cnt_ff <= conv_speed_select_ff ? ADCC_CONV_FAST
                                           : ADCC_CONV_SLOW;
            if (!scan_mode_ff)
              state_ff <= ADCC_IDLE;
            else if (last_pos)
              pos_ff <= 2'h0;
            else
              pos_ff <= pos_ff + 2'h1;
          end
          else
            cnt_ff <= cnt_ff - 9'h001;
        default:
          state_ff <= ADCC_IDLE;
      endcase
    end
  end

  // channel and sample outputs toward the analog core
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      conv_channel <= 3'h0;
      conv_sample  <= 1'b0;
    end
    else
    begin
      conv_channel <= {group_select_ff,
                       scan_mode_ff ? pos_ff : chan_sel_ff};
      conv_sample  <= state_ff == ADCC_CONV;
    end
  end

  // interrupt request follows flag and enable
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      conv_end_irq <= 1'b0;
    else
      conv_end_irq <= conv_end_flag_ff && end_irq_enable_ff;
  end

  // control register read data
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      reg_rdata_ff <= 8'h00;
    else if (bus_rd && bus_addr == ADCC_OFS_CSR)
      reg_rdata_ff <= {conv_end_flag_ff, end_irq_enable_ff,
                       conv_start_bit_ff, scan_mode_ff,
                       conv_speed_select_ff, group_select_ff,
                       chan_sel_ff};
    else if (bus_rd && bus_addr == ADCC_OFS_TRIG)
      reg_rdata_ff <= {ext_trigger_enable_ff, ADCC_TRIG_RES[6:0]};
    else
      reg_rdata_ff <= 8'h00;
  end

  // result storage; slot index equals position in group
  adcc_result_mem u_mem (
    .core_clk (core_clk),
    .nrst     (nrst),
    .standby  (standby),
    .wr_en    (conv_done),
    .wr_idx   (scan_mode_ff ? pos_ff : chan_sel_ff),
    .wr_data  (conv_value),
    .rd_en    (bus_rd && bus_addr[3] == 1'b0),
    .rd_idx   (bus_addr[2:1]),
    .rd_low   (bus_addr[0]),
    .rd_data  (mem_rdata)
  );

  // bus read mux; both sources are registered, so the answer stands
  // two cycles after the strobe and reads zero when no read is in flight
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      bus_rdata <= 8'h00;
    else
      bus_rdata <= rd_mem_ff ? mem_rdata : reg_rdata_ff;
  end
endmodule // adcc_top

// ===== logic/adcc_pkg.sv
package adcc_pkg;
  // register byte offsets on the 8-bit internal bus
  localparam logic [3:0] ADCC_OFS_RES_A_HI = 4'h0;
  localparam logic [3:0] ADCC_OFS_CSR      = 4'h8;
  localparam logic [3:0] ADCC_OFS_TRIG     = 4'h9;
  // control/status and trigger field positions
  localparam int ADCC_BIT_END   = 7;
  localparam int ADCC_BIT_IEN   = 6;
  localparam int ADCC_BIT_START = 5;
  localparam int ADCC_BIT_SCAN  = 4;
  localparam int ADCC_BIT_SPEED = 3;
  localparam int ADCC_BIT_GROUP = 2;
  localparam int ADCC_BIT_TEN   = 7;
  // reset values
  localparam logic [7:0] ADCC_CSR_RST  = 8'h00;
  localparam logic [7:0] ADCC_TRIG_RST = 8'h7F;
  localparam logic [7:0] ADCC_TRIG_RES = 8'h7F;
  // conversion times in states (clock cycles), maximum figures
  localparam int ADCC_CONV_SLOW_ST = 266;
  localparam int ADCC_CONV_FAST_ST = 134;
  localparam logic [8:0] ADCC_CONV_SLOW = 9'(ADCC_CONV_SLOW_ST - 1);
  localparam logic [8:0] ADCC_CONV_FAST = 9'(ADCC_CONV_FAST_ST - 1);
  // converter sequencer states
  typedef enum logic [1:0] {
    ADCC_IDLE = 2'b01,
    ADCC_CONV = 2'b10
  } adcc_state_t;
endpackage

// ===== logic/adcc_result_mem.sv
`timescale 1ns/1ps
// four 10-bit result words, registered byte read with lower-byte latch
module adcc_result_mem
  import adcc_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic       standby,
  // write side from the sequencer
  input  wire logic       wr_en,
  input  wire logic [1:0] wr_idx,
  input  wire logic [9:0] wr_data,
  // read side
  input  wire logic       rd_en,
  input  wire logic [1:0] rd_idx,
  input  wire logic       rd_low,
  output logic      [7:0] rd_data
);
  logic [9:0] mem_ff [4];
  logic [7:0] hold_ff;

  // result storage, cleared by reset and standby
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      for (int i = 0; i < 4; i++) mem_ff[i] <= 10'h000;
    else if (standby)
      for (int i = 0; i < 4; i++) mem_ff[i] <= 10'h000;
    else if (wr_en)
      mem_ff[wr_idx] <= wr_data;
  end

  // lower-byte holding latch, loaded by an upper-byte read
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      hold_ff <= 8'h00;
    else if (standby)
      hold_ff <= 8'h00;
    else if (rd_en && !rd_low)
      hold_ff <= {mem_ff[rd_idx][1:0], 6'h00};
  end

  // registered read data
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      rd_data <= 8'h00;
    else if (rd_en)
      rd_data <= rd_low ? hold_ff
                        : mem_ff[rd_idx][9:2];
  end
endmodule // adcc_result_mem

// ===== tb/adcc_analog_model.sv
`timescale 1ns/1ps
// analog core stand-in: outputs the level of the sampled input while sampling
module adcc_analog_model
  import adcc_pkg::*;
(
  // clock
  input  wire logic        core_clk,
  // ten bits of level per input
  input  wire logic [79:0] levels,
  // converter side
  input  wire logic [2:0]  conv_channel,
  input  wire logic        conv_sample,
  output logic      [9:0]  conv_value
);
  // idle output churns so a stale capture shows up
  initial conv_value = 10'h000;
  always @(posedge core_clk)
    if (conv_sample)
      conv_value <= levels[10*int'(conv_channel) +: 10];
    else
      conv_value <= ~conv_value;
endmodule // adcc_analog_model

// ===== tb/adcc_top_assertions.sv
`timescale 1ns/1ps
// port-level checks of the converter control block
module adcc_chk
  import adcc_pkg::*;
(
  // clock and reset
  input wire logic       core_clk,
  input wire logic       nrst,
  input wire logic       standby,
  // register bus
  input wire logic [3:0] bus_addr,
  input wire logic       bus_rd,
  input wire logic       bus_wr,
  input wire logic [7:0] bus_wdata,
  input wire logic [7:0] bus_rdata,
  // converter side
  input wire logic [2:0] conv_channel,
  input wire logic       conv_sample,
  input wire logic       conv_end_irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // decoded control writes
  logic csr_wr;
  logic go_wr;
  assign csr_wr = bus_wr && !standby && bus_addr == ADCC_OFS_CSR;
  assign go_wr = csr_wr && bus_wdata[ADCC_BIT_START] && !conv_sample;
  // single starts by speed
  sequence s_slow;
    go_wr && !bus_wdata[4] && !bus_wdata[3];
  endsequence
  sequence s_fast;
    go_wr && !bus_wdata[4] && bus_wdata[3];
  endsequence
  // first input converted after a start
  property p_first;
    logic [2:0] ch;
    (go_wr, ch = bus_wdata[4] ? {bus_wdata[2], 2'b00} : bus_wdata[2:0])
      |-> ##2 conv_channel == ch;
  endproperty
  a_stby_clear: assert property (standby |-> ##2
    !conv_sample && !conv_end_irq)
    else $error("converter active after standby");
  a_sw_start: assert property (go_wr |-> ##[1:2] conv_sample)
    else $error("start write did not start");
  a_sw_stop: assert property (csr_wr && !bus_wdata[5]
    |-> ##[1:3] !conv_sample)
    else $error("start clear did not stop");
  a_slow_len: assert property (s_slow |-> ##2 conv_sample
    ##[1:266] !conv_sample)
    else $error("slow conversion too long");
  a_fast_len: assert property (s_fast |-> ##2 conv_sample
    ##[1:134] !conv_sample)
    else $error("fast conversion too long");
  a_first_chan: assert property (p_first)
    else $error("wrong first input");
  a_irq_cause: assert property ($rose(conv_end_irq) |->
    $past(conv_sample) || $past(conv_sample, 2) || $past(bus_wr, 2))
    else $error("irq without conversion end");
  a_low_zero: assert property (bus_rd && bus_addr < 4'h8 && bus_addr[0]
    |-> ##2 bus_rdata[5:0] == 6'h00)
    else $error("low result bits not zero");
  a_trig_ones: assert property (bus_rd && bus_addr == ADCC_OFS_TRIG
    |-> ##2 bus_rdata[6:0] == 7'h7F)
    else $error("trigger spare bits not one");
endmodule // adcc_chk
bind adcc_top adcc_chk adcc_chk_inst (.core_clk(core_clk), .nrst(nrst),
  .standby(standby), .bus_addr(bus_addr), .bus_rd(bus_rd), .bus_wr(bus_wr),
  .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .conv_channel(conv_channel),
  .conv_sample(conv_sample), .conv_end_irq(conv_end_irq));

// ===== tb/testbench.sv
`timescale 1ns/1ps
// self-checking bench for the converter control block
module testbench
  import adcc_pkg::*;
;
  logic        core_clk, nrst, standby, bus_rd, bus_wr, ext_trigger_n;
  logic        conv_sample, conv_end_irq;
  logic [1:0]  rd_q;
  logic [3:0]  bus_addr;
  logic [7:0]  bus_wdata, bus_rdata, cfg;
  logic [2:0]  conv_channel;
  logic [9:0]  conv_value, lv;
  logic [79:0] levels;
  logic [31:0] rng;
  logic [7:0]  exp_q[$];
  int          failures, n_checks, n;

  adcc_top adcc_top_inst (.core_clk(core_clk), .nrst(nrst),
    .standby(standby), .bus_addr(bus_addr), .bus_rd(bus_rd), .bus_wr(bus_wr),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .ext_trigger_n(ext_trigger_n), .conv_channel(conv_channel),
    .conv_sample(conv_sample), .conv_value(conv_value),
    .conv_end_irq(conv_end_irq));
  adcc_analog_model adcc_analog_model_inst (.core_clk(core_clk),
    .levels(levels), .conv_channel(conv_channel), .conv_sample(conv_sample),
    .conv_value(conv_value));

  // 100 MHz clock
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  task automatic chk(input string nm, input logic [9:0] s, input logic [9:0] e);
    n_checks++;
    if (s !== e)
    begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic close_out;
    if (failures == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge core_clk);
    bus_addr = a;
    bus_wdata = d;
    bus_wr = 1'b1;
    @(negedge core_clk);
    bus_wr = 1'b0;
  endtask

  // note the expected byte; the collector compares it
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(negedge core_clk);
    bus_addr = a;
    bus_rd = 1'b1;
    exp_q.push_back(e);
    @(negedge core_clk);
    bus_rd = 1'b0;
  endtask

  // read data lands two cycles after the strobe
  always @(posedge core_clk) rd_q <= {rd_q[0], bus_rd};
  always @(negedge core_clk)
    if (rd_q[1])
      chk("rdata", {2'b00, bus_rdata}, {2'b00, exp_q.pop_front()});

  task automatic wait_idle(output int c);
    c = 2;
    repeat (2) @(negedge core_clk);
    while (conv_sample === 1'b1 && c < 600)
    begin
      @(negedge core_clk);
      c++;
    end
  endtask

  // hang guard
  initial
  begin
    repeat (10000) @(posedge core_clk);
    failures++;
    close_out();
  end

  // main sequence
  initial
  begin
    {nrst, standby, bus_rd, bus_wr, bus_addr, bus_wdata} = '0;
    ext_trigger_n = 1'b1;
    rng = 32'd19876;
    for (int i = 0; i < 8; i++)
    begin
      rng = xs(rng);
      levels[10*i +: 10] = rng[9:0];
    end
    repeat (16) @(posedge core_clk);
    @(negedge core_clk);
    nrst = 1'b1;
    rd(ADCC_OFS_CSR, ADCC_CSR_RST);
    rd(ADCC_OFS_TRIG, ADCC_TRIG_RST);
    wr(ADCC_OFS_TRIG, 8'h80);
    rd(ADCC_OFS_TRIG, 8'hFF);
    wr(ADCC_OFS_TRIG, 8'h00);
    rd(ADCC_OFS_TRIG, 8'h7F);
    wr(ADCC_OFS_CSR, 8'h80);
    rd(ADCC_OFS_CSR, 8'h00);
    // single conversion on every input, both speeds, irq on and off
    for (int c = 0; c < 8; c++)
    begin
      cfg = 8'h20 | 8'(c) | (c[1] ? 8'h08 : 8'h00) | (c[0] ? 8'h40 : 8'h00);
      lv = levels[10*c +: 10];
      wr(ADCC_OFS_CSR, cfg);
      wait_idle(n);
      chk("conv_len", {9'h0, n <= (c[1] ? 136 : 268)}, 10'h001);
      chk("irq", {9'h0, conv_end_irq}, {9'h0, c[0]});
      rd(ADCC_OFS_CSR, cfg ^ 8'hA0);
      rd({1'b0, c[1:0], 1'b0}, lv[9:2]);
      rd({1'b0, c[1:0], 1'b1}, {lv[1:0], 6'h00});
      wr(ADCC_OFS_CSR, cfg & 8'h5F);
      rd(ADCC_OFS_CSR, cfg & 8'h5F);
    end
    // scan over three inputs of the upper group
    wr(ADCC_OFS_CSR, 8'h76);
    n = 0;
    while (conv_end_irq !== 1'b1 && n < 1000)
    begin
      @(negedge core_clk);
      n++;
    end
    chk("scan_wait", {9'h0, n > 760 && n < 820}, 10'h001);
    chk("scan_run", {9'h0, conv_sample}, 10'h001);
    rd(ADCC_OFS_CSR, 8'hF6);
    rd(ADCC_OFS_RES_A_HI + 4'h4, levels[69:62]);
    wr(ADCC_OFS_CSR, 8'h16);
    repeat (2) @(negedge core_clk);
    chk("scan_stop", {9'h0, conv_sample}, 10'h000);
    // falling trigger edge ignored, then honoured
    wr(ADCC_OFS_CSR, 8'h00);
    ext_trigger_n = 1'b0;
    repeat (4) @(negedge core_clk);
    chk("trig_off", {9'h0, conv_sample}, 10'h000);
    ext_trigger_n = 1'b1;
    wr(ADCC_OFS_TRIG, 8'h80);
    ext_trigger_n = 1'b0;
    repeat (4) @(negedge core_clk);
    chk("trig_on", {9'h0, conv_sample}, 10'h001);
    ext_trigger_n = 1'b1;
    // standby in mid-conversion
    standby = 1'b1;
    @(negedge core_clk);
    standby = 1'b0;
    @(negedge core_clk);
    chk("stby", {9'h0, conv_sample}, 10'h000);
    rd(ADCC_OFS_CSR, ADCC_CSR_RST);
    rd(ADCC_OFS_TRIG, ADCC_TRIG_RST);
    repeat (4) @(negedge core_clk);
    close_out();
  end
endmodule // testbench
